// ### ptd_pkg.sv
// Constants, types and helpers for the power-down timer and offset DAC register bank.
`default_nettype none
// Operation
// RULE1: Inactivity timer register at pointer 0x10, read/write, resets to 0x40.
// RULE2: Host writes timer bit 7 as zero and bit 6 as one.
// RULE3: No comparator activity for programmed period puts the part into power-down.
// RULE4: Timeout period is field value times four hours.
// RULE5: Timeout field zero disables the timer; no automatic power-down.
// RULE6: Power-down ends on a serial interface command or a power cycle.
// RULE7: Offset DAC registers at 0x11 and 0x12, read/write, reset to 0xC0.
// RULE8: Bit 7 enables that channel's offset capacitance DAC.
// RULE9: Bit 6 enables automatic offset tracking, only in adaptive threshold mode.
// RULE10: Tracking raises code above three quarters range, lowers below one quarter.
// RULE11: Tracking step size depends on the selected capacitive input range.
// RULE12: Fixed threshold mode keeps tracking off whatever bit 6 says.
// RULE13: Bits 5 to 0 hold the linear 6-bit offset code.
// RULE14: Read-only 32-bit per-part serial number at pointers 0x13 to 0x16.
// RULE15: Read-only identification byte at 0x17; writes leave it unchanged.
// RULE16: Power-down stops conversion circuits but keeps the registers reachable.
// RULE17: Timer restarts on comparator activity and on any rewrite of the field.
// RULE18: Tracking saturates at codes zero and 0x3F, never wrapping.
package ptd_pkg;

	// Register pointers.
	localparam logic [7:0] PTD_PTR_TIMER = 8'h10;
	localparam logic [7:0] PTD_PTR_DAC1 = 8'h11;
	localparam logic [7:0] PTD_PTR_DAC2 = 8'h12;
	localparam logic [7:0] PTD_PTR_SERIAL0 = 8'h13;
	localparam logic [7:0] PTD_PTR_SERIAL1 = 8'h14;
	localparam logic [7:0] PTD_PTR_SERIAL2 = 8'h15;
	localparam logic [7:0] PTD_PTR_SERIAL3 = 8'h16;
	localparam logic [7:0] PTD_PTR_PART_IDENTIFICATION = 8'h17;

	// Reset values and read value of an unmapped pointer.
	localparam logic [7:0] PTD_TIMER_RESET = 8'h40;
	localparam logic [7:0] PTD_DAC_RESET = 8'hC0;
	localparam logic [7:0] PTD_READ_UNMAPPED = 8'h00;

	// Field positions.
	localparam int PTD_DAC_EN_BIT = 7;
	localparam int PTD_DAC_AUTO_BIT = 6;
	localparam int PTD_FIELD_MSB = 5;
	localparam int PTD_FIELD_W = 6;
	localparam logic [5:0] PTD_CODE_MAX = 6'h3F;
	localparam logic [5:0] PTD_CODE_MIN = 6'h00;
	localparam logic [5:0] PTD_TIMEOUT_OFF = 6'h00;

	// Time base: one timeout step is four hours at the 20 MHz system clock.
	localparam longint unsigned PTD_CLK_HZ = 64'd20_000_000;
	localparam longint unsigned PTD_STEP_HOURS = 64'd4;
	localparam longint unsigned PTD_SEC_PER_HOUR = 64'd3600;
	localparam longint unsigned PTD_STEP_CYCLES_DEF = PTD_STEP_HOURS * PTD_SEC_PER_HOUR * PTD_CLK_HZ;
	localparam int PTD_STEP_CNT_W = 40;

	// Converter data average and the tracking thresholds at one and three quarters of range.
	localparam int PTD_AVG_W = 16;
	localparam logic [15:0] PTD_AVG_UPPER = 16'hC000;
	localparam logic [15:0] PTD_AVG_LOWER = 16'h4000;

	// Tracking step per capacitive input range setting.
	localparam int PTD_RANGE_W = 2;
	localparam logic [5:0] PTD_STEP_RANGE0 = 6'h01;
	localparam logic [5:0] PTD_STEP_RANGE1 = 6'h02;
	localparam logic [5:0] PTD_STEP_RANGE2 = 6'h04;
	localparam logic [5:0] PTD_STEP_RANGE3 = 6'h08;

	// Arbitrary neutral identification byte.
	localparam logic [7:0] PTD_PART_IDENTIFICATION_DEF = 8'h5A;

	// Byte access from the serial interface engine, by address pointer.
	typedef struct packed {
		logic wr;
		logic [7:0] ptr;
		logic [7:0] wdata;
	} ptd_reg_req_s;

	// Per-channel converter result feeding the tracking logic.
	typedef struct packed {
		logic valid;
		logic [15:0] average;
	} ptd_avg_s;

	// Step size chosen by input range.
	function automatic logic [5:0] ptd_range_step(input logic [1:0] range);
		logic [5:0] s;
		s = PTD_STEP_RANGE0;
		case (range)
			2'h1: s = PTD_STEP_RANGE1;
			2'h2: s = PTD_STEP_RANGE2;
			2'h3: s = PTD_STEP_RANGE3;
			default: s = PTD_STEP_RANGE0;
		endcase
		return s;
	endfunction

	// Saturating step of a 6-bit code in either direction.
	function automatic logic [5:0] ptd_sat_step(input logic [5:0] code, input logic [5:0] step,
		input logic up);
		logic [6:0] sum;
		logic [5:0] r;
		sum = 7'h00;
		r = code;
		if (up) begin
			sum = {1'b0, code} + {1'b0, step};
			r = (sum > {1'b0, PTD_CODE_MAX}) ? PTD_CODE_MAX : sum[5:0];
		end else begin
			r = (code < step) ? PTD_CODE_MIN : code - step;
		end
		return r;
	endfunction

endpackage

`default_nettype wire

// ### ptd_regs.sv
// Power-down timer, offset DAC, serial number and identification register bank.
`timescale 1ns/1ps
`default_nettype none

module ptd_regs
	import ptd_pkg::*;
#(
	parameter longint unsigned STEP_CYCLES = PTD_STEP_CYCLES_DEF
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire ptd_reg_req_s reg_req,
	output logic [7:0] reg_rdata,
	input wire logic [1:0] comparator_active,
	input wire logic wake_cmd,
	input wire logic adaptive_mode,
	input wire logic [1:0] cap_range,
	input wire ptd_avg_s avg_ch1,
	input wire ptd_avg_s avg_ch2,
	input wire logic [31:0] fuse_serial,
	output logic powerdown,
	output logic conversion_enable,
	output logic [1:0] offset_dac_enable,
	output logic [5:0] offset_code_ch1,
	output logic [5:0] offset_code_ch2
);

	logic [7:0] timer_q;
	logic [7:0] dac1_q;
	logic [7:0] dac2_q;
	logic [7:0] rdata_q;
	logic [31:0] serial_meta_q;
	logic [31:0] serial_q;
	logic powerdown_q;
	logic [PTD_STEP_CNT_W-1:0] step_cnt_q;
	logic [5:0] steps_q;
	logic [5:0] timeout;
	logic step_wrap;
	logic timer_restart;
	logic timer_write;
	logic dac1_write;
	logic dac2_write;
	logic track_allowed;
	logic [5:0] track_step;

	assign timeout = timer_q[PTD_FIELD_MSB:0];
	assign timer_write = reg_req.wr && (reg_req.ptr == PTD_PTR_TIMER);
	assign dac1_write = reg_req.wr && (reg_req.ptr == PTD_PTR_DAC1);
	assign dac2_write = reg_req.wr && (reg_req.ptr == PTD_PTR_DAC2);
	assign step_wrap = (step_cnt_q == STEP_CYCLES[PTD_STEP_CNT_W-1:0] - 1'b1);

	// Restart on any comparator activity or a rewrite of the timer register. [RULE17]
	assign timer_restart = (|comparator_active) || timer_write;

	// The whole byte is stored as written; the host keeps bits 7 and 6 at 0 and 1. [RULE1] [RULE2]
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			timer_q <= PTD_TIMER_RESET;
		end else if (timer_write) begin
			timer_q <= reg_req.wdata;
		end
	end

	// Cycle counter for one four-hour step and the count of elapsed steps. [RULE4]
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			step_cnt_q <= '0;
			steps_q <= PTD_TIMEOUT_OFF;
		end else if (timer_restart || powerdown_q || timeout == PTD_TIMEOUT_OFF) begin
			step_cnt_q <= '0; // [RULE5]
			steps_q <= PTD_TIMEOUT_OFF;
		end else if (step_wrap) begin
			step_cnt_q <= '0;
			steps_q <= steps_q + 6'h01;
		end else begin
			step_cnt_q <= step_cnt_q + 1'b1;
		end
	end

	// Expiry of the last step wins over a coincident wake, so no timeout is ever lost.
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			powerdown_q <= 1'b0; // [RULE6]
		end else if (!powerdown_q && !timer_restart && timeout != PTD_TIMEOUT_OFF && step_wrap
			&& (steps_q + 6'h01) == timeout) begin
			powerdown_q <= 1'b1; // [RULE3] [RULE5]
		end else if (wake_cmd) begin
			powerdown_q <= 1'b0; // [RULE6]
		end
	end

	// Conversion and tracking are stopped; register access below is never gated by power-down. [RULE16]
	assign powerdown = powerdown_q;
	assign conversion_enable = !powerdown_q;

	// Tracking needs adaptive mode; in fixed mode the auto bit is ignored. [RULE9] [RULE12]
	assign track_allowed = adaptive_mode && !powerdown_q;
	assign track_step = ptd_range_step(cap_range); // [RULE11]

	// A host write in the same cycle as a tracking step wins, so software always has the last word.
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			dac1_q <= PTD_DAC_RESET; // [RULE7]
		end else if (dac1_write) begin
			dac1_q <= reg_req.wdata;
		end else if (track_allowed && dac1_q[PTD_DAC_AUTO_BIT] && avg_ch1.valid) begin
			if (avg_ch1.average > PTD_AVG_UPPER) begin
				dac1_q[PTD_FIELD_MSB:0] <= ptd_sat_step(dac1_q[PTD_FIELD_MSB:0], track_step,
					1'b1); // [RULE10] [RULE18]
			end else if (avg_ch1.average < PTD_AVG_LOWER) begin
				dac1_q[PTD_FIELD_MSB:0] <= ptd_sat_step(dac1_q[PTD_FIELD_MSB:0], track_step,
					1'b0); // [RULE10] [RULE18]
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			dac2_q <= PTD_DAC_RESET; // [RULE7]
		end else if (dac2_write) begin
			dac2_q <= reg_req.wdata;
		end else if (track_allowed && dac2_q[PTD_DAC_AUTO_BIT] && avg_ch2.valid) begin
			if (avg_ch2.average > PTD_AVG_UPPER) begin
				dac2_q[PTD_FIELD_MSB:0] <= ptd_sat_step(dac2_q[PTD_FIELD_MSB:0], track_step,
					1'b1); // [RULE10] [RULE18]
			end else if (avg_ch2.average < PTD_AVG_LOWER) begin
				dac2_q[PTD_FIELD_MSB:0] <= ptd_sat_step(dac2_q[PTD_FIELD_MSB:0], track_step,
					1'b0); // [RULE10] [RULE18]
			end
		end
	end

	assign offset_dac_enable = {dac2_q[PTD_DAC_EN_BIT], dac1_q[PTD_DAC_EN_BIT]}; // [RULE8]
	assign offset_code_ch1 = dac1_q[PTD_FIELD_MSB:0]; // [RULE13]
	assign offset_code_ch2 = dac2_q[PTD_FIELD_MSB:0]; // [RULE13]

	// Fuse word is static but arrives from outside the clock domain, hence two stages.
	always_ff @(posedge clk_sys) begin
		serial_meta_q <= fuse_serial;
		serial_q <= serial_meta_q;
	end

	// Read data registered one cycle after the pointer; read-only bytes ignore writes.
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			rdata_q <= PTD_READ_UNMAPPED;
		end else if (reg_req.ptr == PTD_PTR_TIMER) begin
			rdata_q <= timer_q;
		end else if (reg_req.ptr == PTD_PTR_DAC1) begin
			rdata_q <= dac1_q;
		end else if (reg_req.ptr == PTD_PTR_DAC2) begin
			rdata_q <= dac2_q;
		end else if (reg_req.ptr == PTD_PTR_SERIAL0) begin
			rdata_q <= serial_q[31:24]; // [RULE14]
		end else if (reg_req.ptr == PTD_PTR_SERIAL1) begin
			rdata_q <= serial_q[23:16]; // [RULE14]
		end else if (reg_req.ptr == PTD_PTR_SERIAL2) begin
			rdata_q <= serial_q[15:8]; // [RULE14]
		end else if (reg_req.ptr == PTD_PTR_SERIAL3) begin
			rdata_q <= serial_q[7:0]; // [RULE14]
		end else if (reg_req.ptr == PTD_PTR_PART_IDENTIFICATION) begin
			rdata_q <= PTD_PART_IDENTIFICATION_DEF; // [RULE15]
		end else begin
			rdata_q <= PTD_READ_UNMAPPED;
		end
	end

	assign reg_rdata = rdata_q;

endmodule

`default_nettype wire

// ### ptd_regs_sva.sv
// Port assertions for the register bank.
`timescale 1ns/1ps
`default_nettype none
module ptd_regs_sva
	import ptd_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire ptd_reg_req_s reg_req,
	input wire logic [7:0] reg_rdata,
	input wire logic [1:0] comparator_active,
	input wire logic wake_cmd,
	input wire logic adaptive_mode,
	input wire ptd_avg_s avg_ch1,
	input wire logic powerdown,
	input wire logic conversion_enable,
	input wire logic [1:0] offset_dac_enable,
	input wire logic [5:0] offset_code_ch1,
	input wire logic [5:0] offset_code_ch2
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	chk_pd_holds: assert property (powerdown && !wake_cmd |=> powerdown)
		else $error("powerdown dropped");
	chk_wake_clears: assert property (powerdown && wake_cmd |=> !powerdown)
		else $error("wake ignored");
	chk_conv_gated: assert property (conversion_enable != powerdown)
		else $error("conversion not gated");
	chk_pd_quiet: assert property ($rose(powerdown) |-> $past(comparator_active) == 2'h0)
		else $error("powerdown despite activity");
	chk_en_write: assert property (reg_req.wr && reg_req.ptr == 8'h11 |=>
		offset_dac_enable[0] == $past(reg_req.wdata[7])) else $error("dac enable wrong");
	chk_code_write: assert property (reg_req.wr && reg_req.ptr == 8'h12 |=>
		offset_code_ch2 == $past(reg_req.wdata[5:0])) else $error("code wrong");
	chk_id_read: assert property (reg_req.ptr == 8'h17 |=> reg_rdata == 8'h5A)
		else $error("id wrong");
	chk_fixed_frozen: assert property (!adaptive_mode && !reg_req.wr |=>
		$stable(offset_code_ch1)) else $error("tracking in fixed mode");
	chk_top_sat: assert property (avg_ch1.valid && offset_code_ch1 == 6'h3F &&
		avg_ch1.average > 16'hC000 && !reg_req.wr |=> offset_code_ch1 == 6'h3F)
		else $error("code wrapped");
	cov_pd: cover property ($rose(powerdown));
	cov_wake: cover property (powerdown && wake_cmd);
	cov_track: cover property (avg_ch1.valid && adaptive_mode);
endmodule
bind ptd_regs ptd_regs_sva u_sva (.clk_sys(clk_sys), .rst_n(rst_n), .reg_req(reg_req),
	.reg_rdata(reg_rdata), .comparator_active(comparator_active), .wake_cmd(wake_cmd),
	.adaptive_mode(adaptive_mode), .avg_ch1(avg_ch1), .powerdown(powerdown),
	.conversion_enable(conversion_enable), .offset_dac_enable(offset_dac_enable),
	.offset_code_ch1(offset_code_ch1), .offset_code_ch2(offset_code_ch2));
`default_nettype wire

// ### ptd_host.sv
// Host model issuing byte writes and reads to the register bank.
`timescale 1ns/1ps
`default_nettype none
module ptd_host
	import ptd_pkg::*;
(
	input wire logic clk_sys,
	output var ptd_reg_req_s reg_req,
	input wire logic [7:0] reg_rdata
);
	initial reg_req = '0;
	task automatic wr(input logic [7:0] p, input logic [7:0] d);
		@(posedge clk_sys);
		#1 reg_req = '{1'b1, p, d};
		@(posedge clk_sys);
		#1 reg_req.wr = 1'b0;
	endtask
	task automatic rd(input logic [7:0] p, output logic [7:0] d);
		@(posedge clk_sys);
		#1 reg_req.ptr = p;
		@(posedge clk_sys);
		#1 d = reg_rdata;
	endtask
endmodule
`default_nettype wire

// ### ptd_regs_tb_top.sv
// Self-checking testbench for the register bank.
`timescale 1ns/1ps
`default_nettype none
module ptd_regs_tb_top
	import ptd_pkg::*;
;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	ptd_reg_req_s reg_req;
	logic [7:0] reg_rdata, rd_v;
	logic [1:0] comparator_active = 2'h0;
	logic wake_cmd = 1'b0;
	logic adaptive_mode = 1'b0;
	logic [1:0] cap_range = 2'h3;
	ptd_avg_s avg_ch1 = '0;
	logic powerdown, conversion_enable;
	logic [1:0] offset_dac_enable;
	logic [5:0] offset_code_ch1, offset_code_ch2;
	int num_errors = 0;
	int checks = 0;
	logic [23:0] rows [9] = '{24'h118585, 24'h127F7F, 24'h104040, 24'h130012, 24'h14FF34,
		24'h150056, 24'h160078, 24'h17FF5A, 24'h201100};
	always #25 clk_sys = ~clk_sys;
	ptd_host u_host (.clk_sys(clk_sys), .reg_req(reg_req), .reg_rdata(reg_rdata));
	ptd_regs #(.STEP_CYCLES(64'd4)) u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_req(reg_req),
		.reg_rdata(reg_rdata), .comparator_active(comparator_active), .wake_cmd(wake_cmd),
		.adaptive_mode(adaptive_mode), .cap_range(cap_range), .avg_ch1(avg_ch1), .avg_ch2(17'h0),
		.fuse_serial(32'h12345678), .powerdown(powerdown), .conversion_enable(conversion_enable),
		.offset_dac_enable(offset_dac_enable), .offset_code_ch1(offset_code_ch1),
		.offset_code_ch2(offset_code_ch2));
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
		checks++;
		if (s !== e) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic pulse(input logic [15:0] a);
		@(posedge clk_sys);
		#1 avg_ch1 = '{1'b1, a};
		@(posedge clk_sys);
		#1 avg_ch1.valid = 1'b0;
	endtask
	task automatic close_out();
		$display("checks %0d num_errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	initial begin
		#100000;
		num_errors++;
		close_out();
	end
	initial begin
		repeat (16) @(posedge clk_sys);
		#1 rst_n = 1'b1;
		u_host.rd(8'h10, rd_v);
		chk("timer_rst", 8'h40, rd_v);
		u_host.rd(8'h12, rd_v);
		chk("dac_rst", 8'hC0, rd_v);
		foreach (rows[i]) begin
			u_host.wr(rows[i][23:16], rows[i][15:8]);
			u_host.rd(rows[i][23:16], rd_v);
			chk("row", rows[i][7:0], rd_v);
		end
		chk("dac_en", 8'h01, {6'h0, offset_dac_enable});
		u_host.wr(8'h10, 8'h42);
		repeat (2) @(posedge clk_sys);
		#1 comparator_active = 2'h1;
		@(posedge clk_sys);
		#1 comparator_active = 2'h0;
		repeat (7) @(posedge clk_sys);
		#1 chk("pd_early", 8'h00, {7'h0, powerdown});
		repeat (4) @(posedge clk_sys);
		#1 chk("pd_due", 8'h01, {7'h0, powerdown});
		u_host.rd(8'h10, rd_v);
		chk("pd_read", 8'h42, rd_v);
		u_host.wr(8'h10, 8'h40);
		@(posedge clk_sys);
		#1 wake_cmd = 1'b1;
		@(posedge clk_sys);
		#1 wake_cmd = 1'b0;
		chk("woken", 8'h01, {7'h0, conversion_enable});
		// Longer than 64 steps, so a timer that ignored the zero field would have expired.
		repeat (300) @(posedge clk_sys);
		#1 chk("pd_off", 8'h00, {7'h0, powerdown});
		adaptive_mode = 1'b1;
		u_host.wr(8'h11, 8'hFE);
		pulse(16'hD000);
		chk("sat_top", 8'h3F, {2'h0, offset_code_ch1});
		pulse(16'hD000);
		chk("sat_hold", 8'h3F, {2'h0, offset_code_ch1});
		pulse(16'h1000);
		chk("step_dn", 8'h37, {2'h0, offset_code_ch1});
		pulse(16'hC000);
		chk("at_upper", 8'h37, {2'h0, offset_code_ch1});
		cap_range = 2'h0;
		pulse(16'hD000);
		chk("step_rng0", 8'h38, {2'h0, offset_code_ch1});
		adaptive_mode = 1'b0;
		pulse(16'h1000);
		chk("fixed", 8'h38, {2'h0, offset_code_ch1});
		u_host.wr(8'h10, 8'h41);
		repeat (6) @(posedge clk_sys);
		#1 chk("pd_again", 8'h01, {7'h0, powerdown});
		rst_n = 1'b0;
		repeat (2) @(posedge clk_sys);
		#1 rst_n = 1'b1;
		chk("pd_reset", 8'h00, {7'h0, powerdown});
		u_host.rd(8'h11, rd_v);
		chk("dac1_reset", 8'hC0, rd_v);
		close_out();
	end
endmodule
`default_nettype wire
